/* File: hdl/cls_regs.vh */
// Summary of operation
// - last_error_code sits in bits 2:0 of protocol_status, resets to 000 and shows the kind of the latest bus error.
// - a message received or transmitted without any error sets last_error_code to 0x0.
// - the device never produces code 111, and software may write 111 so that any later change shows a new bus event.
// - a stuff error (more than 5 equal bits in a row where stuffing forbids it) records code 0x1.
// - a form error in a fixed-format part of a received frame records code 0x2.
// - a transmitted message that no node acknowledges records code 0x3.
// - driving recessive but sampling dominant outside arbitration while transmitting records code 0x4.
// - driving dominant (ack bit, error flag and overload flag included) but sampling recessive records code 0x5.
// - during busoff recovery every run of 11 recessive bits writes code 0x5.
// - a received checksum that does not match the computed CRC records code 0x6.
// - transmit_success_flag sits in bit 3 of protocol_status, resets to 0 and is set by every successful transmission.
// - only a software write of zero clears transmit_success_flag, which then reads 0 until the next success.
// - a transmission counts as successful only if it was error free and acknowledged by another node.
// - device updates of last_error_code or transmit_success_flag raise a status-change interrupt when enabled.
// - reading protocol_status clears the pending status identifier 0x8000 of the interrupt identification register.
`ifndef CLS_REGS_VH
`define CLS_REGS_VH

`define CLS_ADR_CONTROL 32'h4005_0000
`define CLS_ADR_STATUS 32'h4005_0004
`define CLS_ADR_INT_ID 32'h4005_0010
`define CLS_ADR_IRQ_STATUS 32'h4005_0100
`define CLS_ADR_IRQ_MASK 32'h4005_0104

`define CLS_CTRL_SIE_BIT 2
`define CLS_STAT_TRANSMIT_SUCCESS_FLAG_BIT 3
`define CLS_LEC_MSB 2
`define CLS_LEC_LSB 0

`define CLS_LEC_NONE 3'h0
`define CLS_LEC_STUFF 3'h1
`define CLS_LEC_FORM 3'h2
`define CLS_LEC_ACK 3'h3
`define CLS_LEC_REC_MISMATCH 3'h4
`define CLS_LEC_DOM_MISMATCH 3'h5
`define CLS_LEC_CRC 3'h6
`define CLS_LEC_UNUSED 3'h7

`define CLS_INT_ID_STATUS 16'h8000
`define CLS_IRQ_LEC_BIT 0
`define CLS_IRQ_TRANSMIT_SUCCESS_FLAG_BIT 1
`define CLS_RESET_WORD 32'h0000_0000

`endif

/* File: hdl/cls_sticky_bit.v */
`timescale 1ns/10ps
`default_nettype none
module cls_sticky_bit
(
  input wire clk_i, // controller clock
  input wire rst_i, // synchronous reset, high
  input wire set_i, // hardware event
  input wire clr_i, // clear request
  output reg flag_o // sticky flag
);

  // set wins so an event in the clearing cycle survives
  always @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule // cls_sticky_bit
`default_nettype wire

/* File: hdl/cls_status.v */
`timescale 1ns/10ps
`default_nettype none
`include "cls_regs.vh"
module cls_status
(
  input wire clk_i, // controller clock, 250 MHz
  input wire rst_i, // synchronous reset, high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [31:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  input wire stuff_error_i, // pulse: stuff violation seen
  input wire form_error_i, // pulse: fixed-format field wrong
  input wire missing_acknowledge_i, // pulse: own frame not acked
  input wire recessive_drive_mismatch_i, // pulse: sent recessive, saw dominant
  input wire dominant_drive_mismatch_i, // pulse: sent dominant, saw recessive
  input wire checksum_mismatch_i, // pulse: crc wrong on reception
  input wire recovery_idle_run_i, // pulse: 11 recessive bits in busoff recovery
  input wire transfer_ok_i, // pulse: message rx or tx without error
  input wire tx_acked_ok_i, // pulse: own frame error free and acked
  output reg [2:0] last_error_code_o, // current code
  output reg transmit_success_flag_o, // current flag
  output reg irq_o // level interrupt, high
);

  wire req;
  wire wr;
  wire rd;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_istat;
  wire wr_mask;
  wire any_error;
  wire dev_lec_upd;
  wire transmit_success_flag_set;
  wire status_event;
  wire transmit_success_flag_q;
  wire id_pending;
  wire [1:0] istat_q;
  reg [2:0] dev_code;
  reg sie_reg;
  reg [1:0] mask_reg;
  reg [2:0] lec_reg;
  reg [31:0] rdata_next;

  // single-cycle answer; the held request is not retaken while ack is up
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wr_ctrl = wr & (wb_adr_i == `CLS_ADR_CONTROL);
  assign wr_stat = wr & (wb_adr_i == `CLS_ADR_STATUS);
  assign wr_istat = wr & (wb_adr_i == `CLS_ADR_IRQ_STATUS);
  assign wr_mask = wr & (wb_adr_i == `CLS_ADR_IRQ_MASK);

  assign any_error = stuff_error_i | form_error_i | missing_acknowledge_i | recessive_drive_mismatch_i
                   | dominant_drive_mismatch_i | checksum_mismatch_i | recovery_idle_run_i;
  assign dev_lec_upd = any_error | transfer_ok_i;
  assign transmit_success_flag_set = tx_acked_ok_i & ~any_error;
  assign status_event = sie_reg & (dev_lec_upd | transmit_success_flag_set);

  // the protocol engine flags one error per bit time; the order only breaks ties
  always @*
  begin
    dev_code = `CLS_LEC_NONE;
    if (stuff_error_i)
      dev_code = `CLS_LEC_STUFF;
    else if (form_error_i)
      dev_code = `CLS_LEC_FORM;
    else if (missing_acknowledge_i)
      dev_code = `CLS_LEC_ACK;
    else if (recessive_drive_mismatch_i)
      dev_code = `CLS_LEC_REC_MISMATCH;
    else if (dominant_drive_mismatch_i | recovery_idle_run_i)
      dev_code = `CLS_LEC_DOM_MISMATCH;
    else if (checksum_mismatch_i)
      dev_code = `CLS_LEC_CRC;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      lec_reg <= `CLS_LEC_NONE;
    else if (dev_lec_upd)
      lec_reg <= dev_code; // never 111 from here
    else if (wr_stat)
      lec_reg <= wb_dat_i[`CLS_LEC_MSB:`CLS_LEC_LSB];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sie_reg <= 1'b0;
      mask_reg <= 2'b00;
    end
    else
    begin
      if (wr_ctrl)
        sie_reg <= wb_dat_i[`CLS_CTRL_SIE_BIT];
      if (wr_mask)
        mask_reg <= wb_dat_i[1:0];
    end
  end

  // writing a one leaves the flag alone; only a zero clears it
  cls_sticky_bit u_transmit_success_flag
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(transmit_success_flag_set),
    .clr_i(wr_stat & ~wb_dat_i[`CLS_STAT_TRANSMIT_SUCCESS_FLAG_BIT]),
    .flag_o(transmit_success_flag_q)
  );

  cls_sticky_bit u_id_pending
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(status_event),
    .clr_i(rd & (wb_adr_i == `CLS_ADR_STATUS)),
    .flag_o(id_pending)
  );

  cls_sticky_bit u_irq_lec
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(dev_lec_upd),
    .clr_i(wr_istat & wb_dat_i[`CLS_IRQ_LEC_BIT]),
    .flag_o(istat_q[`CLS_IRQ_LEC_BIT])
  );

  cls_sticky_bit u_irq_transmit_success_flag
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(transmit_success_flag_set),
    .clr_i(wr_istat & wb_dat_i[`CLS_IRQ_TRANSMIT_SUCCESS_FLAG_BIT]),
    .flag_o(istat_q[`CLS_IRQ_TRANSMIT_SUCCESS_FLAG_BIT])
  );

  always @*
  begin
    rdata_next = `CLS_RESET_WORD;
    if (wb_adr_i == `CLS_ADR_CONTROL)
      rdata_next[`CLS_CTRL_SIE_BIT] = sie_reg;
    else if (wb_adr_i == `CLS_ADR_STATUS)
    begin
      rdata_next[`CLS_LEC_MSB:`CLS_LEC_LSB] = lec_reg;
      rdata_next[`CLS_STAT_TRANSMIT_SUCCESS_FLAG_BIT] = transmit_success_flag_q;
    end
    else if (wb_adr_i == `CLS_ADR_INT_ID)
      rdata_next[15:0] = id_pending ? `CLS_INT_ID_STATUS : 16'h0000;
    else if (wb_adr_i == `CLS_ADR_IRQ_STATUS)
      rdata_next[1:0] = istat_q;
    else if (wb_adr_i == `CLS_ADR_IRQ_MASK)
      rdata_next[1:0] = mask_reg;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `CLS_RESET_WORD;
      last_error_code_o <= `CLS_LEC_NONE;
      transmit_success_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= rdata_next;
      last_error_code_o <= lec_reg;
      transmit_success_flag_o <= transmit_success_flag_q;
      // one cycle behind the sticky bits, keeps the pin glitch free
      irq_o <= |(istat_q & mask_reg);
    end
  end

endmodule // cls_status
`default_nettype wire

/* File: verification/cls_status_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module cls_status_properties (
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, // clock, reset, bus controls
  input wire [31:0] wb_adr_i, wb_dat_i, // bus address and write data
  input wire [3:0] wb_sel_i, // byte selects
  input wire stuff_error_i, form_error_i, missing_acknowledge_i, recessive_drive_mismatch_i, // events
  input wire dominant_drive_mismatch_i, checksum_mismatch_i, recovery_idle_run_i, transfer_ok_i, tx_acked_ok_i,
  input wire [2:0] last_error_code_o, // code
  input wire transmit_success_flag_o, irq_o // flag, interrupt
);
  wire [8:0] ev = {stuff_error_i, form_error_i, missing_acknowledge_i, recessive_drive_mismatch_i,
    dominant_drive_mismatch_i, checksum_mismatch_i, recovery_idle_run_i, transfer_ok_i, tx_acked_ok_i};
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a: assert property (take |=> ack_pulse) else $error("bus ack not one pulse");
  stuff_code_a: assert property (stuff_error_i |-> ##2 last_error_code_o == 3'h1)
    else $error("stuff code wrong");
  form_code_a: assert property (ev == 9'h080 |-> ##2 last_error_code_o == 3'h2)
    else $error("form code wrong");
  ack_code_a: assert property (ev == 9'h040 |-> ##2 last_error_code_o == 3'h3)
    else $error("acknowledge code wrong");
  rec_code_a: assert property (ev == 9'h020 |-> ##2 last_error_code_o == 3'h4)
    else $error("recessive mismatch code wrong");
  dom_code_a: assert property (ev == 9'h010 |-> ##2 last_error_code_o == 3'h5)
    else $error("dominant mismatch code wrong");
  run_code_a: assert property (ev == 9'h004 |-> ##2 last_error_code_o == 3'h5)
    else $error("recovery code wrong");
  crc_code_a: assert property (ev == 9'h008 |-> ##2 last_error_code_o == 3'h6)
    else $error("checksum code wrong");
  ok_code_a: assert property (ev == 9'h002 |-> ##2 last_error_code_o == 3'h0)
    else $error("clean transfer code wrong");
  tx_flag_a: assert property (ev == 9'h001 |-> ##2 transmit_success_flag_o)
    else $error("transmit flag not set");
  flag_clear_a: assert property ($fell(transmit_success_flag_o) |->
    $past(take & wb_we_i & wb_sel_i[0] & !wb_dat_i[3] & wb_adr_i == 32'h4005_0004, 2)) else $error("flag lost");
  irq_rise_a: assert property ($rose(irq_o) |-> $past((|ev) | take & wb_we_i, 2))
    else $error("interrupt without cause");
endmodule // cls_status_properties
bind cls_status cls_status_properties i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .stuff_error_i, .form_error_i, .missing_acknowledge_i,
  .recessive_drive_mismatch_i, .dominant_drive_mismatch_i, .checksum_mismatch_i, .recovery_idle_run_i,
  .transfer_ok_i, .tx_acked_ok_i, .last_error_code_o, .transmit_success_flag_o, .irq_o);
`default_nettype wire

/* File: verification/cls_bus_node.sv */
`timescale 1ns/10ps
`default_nettype none
module cls_bus_node (
  input wire logic clk_i, // controller clock
  input wire logic fire_i, // launch one bus outcome
  input wire logic [8:0] kind_i, // outcomes that coincide
  output var logic [8:0] ev_o // one-cycle outcome pulses
);
  // registered so pulses never overlap the bench's own edge
  always @(posedge clk_i)
    ev_o <= fire_i ? kind_i : 9'h000;
endmodule // cls_bus_node
`default_nettype wire

/* File: verification/cls_status_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cls_regs.vh"
module cls_status_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fire = 0, ack, txf, irq;
  logic [31:0] adr = '0, dat = '0, rdat, q[$];
  logic [3:0] sel = '0;
  logic [8:0] kind = '0, ev;
  logic [2:0] last_error_code, r;
  logic [2:0] codes[7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h5};
  int err_count = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  cls_bus_node i_node (.clk_i, .fire_i(fire), .kind_i(kind), .ev_o(ev));
  cls_status i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .stuff_error_i(ev[8]), .form_error_i(ev[7]),
    .missing_acknowledge_i(ev[6]), .recessive_drive_mismatch_i(ev[5]), .dominant_drive_mismatch_i(ev[4]),
    .checksum_mismatch_i(ev[3]), .recovery_idle_run_i(ev[2]), .transfer_ok_i(ev[1]), .tx_acked_ok_i(ev[0]),
    .last_error_code_o(last_error_code), .transmit_success_flag_o(txf), .irq_o(irq));
  task chk(input logic [31:0] s, e, input string n);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task rd(input logic [31:0] a, e);
    q.push_back(e);
    bus(0, a, '0, 4'hf);
  endtask
  // ends on a falling edge so the interrupt level has settled
  task fire_ev(input logic [8:0] k);
    @(posedge clk_i);
    {fire, kind} <= {1'b1, k};
    @(posedge clk_i);
    fire <= 0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0)
      chk(rdat, q.pop_front(), "read data");
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(32'h8afb940d));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(`CLS_ADR_STATUS, '0);
    rd(`CLS_ADR_INT_ID, '0);
    rd(32'h4005_0020, '0);
    $display("reset values done");
    for (int k = 0; k < 7; k++)
    begin
      bus(1, `CLS_ADR_STATUS, 32'h7, 4'hf);
      rd(`CLS_ADR_STATUS, 32'h7);
      fire_ev(9'h100 >> k);
      chk(last_error_code, codes[k], "code port");
      rd(`CLS_ADR_STATUS, codes[k]);
    end
    $display("error codes done");
    fire_ev(9'h101);
    rd(`CLS_ADR_STATUS, 32'h1);
    fire_ev(9'h002);
    rd(`CLS_ADR_STATUS, '0);
    fire_ev(9'h001);
    chk(txf, 1, "flag port");
    rd(`CLS_ADR_STATUS, 32'h8);
    r = $urandom;
    bus(1, `CLS_ADR_STATUS, {28'h0, 1'b1, r}, 4'hf);
    bus(1, `CLS_ADR_STATUS, '0, 4'he);
    rd(`CLS_ADR_STATUS, {28'h0, 1'b1, r});
    bus(1, `CLS_ADR_STATUS, '0, 4'h1);
    rd(`CLS_ADR_STATUS, '0);
    chk(txf, 0, "flag port cleared");
    $display("transmit flag done");
    bus(1, `CLS_ADR_CONTROL, 32'h4, 4'hf);
    bus(1, `CLS_ADR_IRQ_MASK, 32'h3, 4'hf);
    fire_ev(9'h001);
    chk(irq, 1, "irq raised");
    rd(`CLS_ADR_INT_ID, 32'h8000);
    rd(`CLS_ADR_STATUS, 32'h8);
    rd(`CLS_ADR_INT_ID, '0);
    bus(1, `CLS_ADR_IRQ_STATUS, 32'h3, 4'hf);
    bus(1, `CLS_ADR_STATUS, 32'h7, 4'hf);
    rd(`CLS_ADR_IRQ_STATUS, '0);
    chk(irq, 0, "irq cleared");
    bus(1, `CLS_ADR_IRQ_MASK, '0, 4'hf);
    fire_ev(9'h100);
    chk(irq, 0, "irq masked");
    rd(`CLS_ADR_IRQ_STATUS, 32'h1);
    $display("interrupt done");
    print_verdict;
  end
endmodule // cls_status_test
`default_nettype wire
